// ===== rtl/adcr_pkg.sv
// Shared constants for the converter control and result unit
package adcr_pkg;
	// Register byte addresses
	localparam logic [15:0] ADDR_CONTROL = 16'hffa0;
	localparam logic [15:0] ADDR_RESULT  = 16'hffa2;
	localparam logic [15:0] ADDR_PORT    = 16'hffa4;
	// Control register fields
	localparam int CHAN_LSB  = 0;
	localparam int MODE_LSB  = 4;
	localparam int START_BIT = 7;
	localparam int BUSY_BIT  = 8;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] RESULT_RESET  = 16'h0000;
	// Result register fields
	localparam int RESULT_LSB = 0;
	localparam int CHNUM_LSB  = 12;
	// Channel count and last valid code
	localparam int           NUM_CHANNELS = 10;
	localparam logic [3:0]   LAST_CHANNEL = 4'h9;
	// Conversion timing at the system clock
	localparam int CLK_PERIOD_PS = 25000;
	localparam int T_SAMPLE_PS   = 1575000;
	localparam int T_HOLD_PS     = 8175000;
	localparam int SAMPLE_CYC    = (T_SAMPLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_CYC      = (T_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CONVERT_CYC   = SAMPLE_CYC + HOLD_CYC;

	typedef enum logic [1:0] {
		MODE_SINGLE      = 2'b00,
		MODE_SINGLE_CONT = 2'b01,
		MODE_SCAN        = 2'b10,
		MODE_SCAN_CONT   = 2'b11
	} adcr_mode_type;

	typedef enum logic {
		ST_IDLE    = 1'b0,
		ST_CONVERT = 1'b1
	} adcr_state_type;
endpackage

// ===== rtl/adcr_pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module adcr_pin_sync #(
	parameter int WIDTH = 10
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] out_r;
	logic [WIDTH-1:0] out_nxt;

	initial begin
		if (WIDTH < 1) $error("adcr_pin_sync: WIDTH must be positive");
	end

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			out_r <= '0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign pin_out = out_r;
endmodule

// ===== rtl/adcr_conv_timer.sv
// Sample and hold phase timer for one conversion
`timescale 1ns/1ps
module adcr_conv_timer #(
	parameter int SAMPLE = adcr_pkg::SAMPLE_CYC,
	parameter int TOTAL  = adcr_pkg::CONVERT_CYC
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic launch,
	output logic      sampling,
	output logic      done
);
	localparam int CW = $clog2(TOTAL + 1);
	localparam logic [CW-1:0] SAMPLE_END = CW'(SAMPLE - 1);
	localparam logic [CW-1:0] TOTAL_END  = CW'(TOTAL - 1);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          run_r;
	logic          run_nxt;
	logic          samp_r;
	logic          samp_nxt;
	logic          done_r;
	logic          done_nxt;

	initial begin
		if (SAMPLE < 1 || TOTAL <= SAMPLE) $error("adcr_conv_timer: need 1 <= SAMPLE < TOTAL");
	end

	always_comb begin
		cnt_nxt  = cnt_r;
		run_nxt  = run_r;
		samp_nxt = samp_r;
		done_nxt = 1'b0;
		if (launch) begin
			// A new launch aborts any conversion in flight
			cnt_nxt  = '0;
			run_nxt  = 1'b1;
			samp_nxt = 1'b1;
		end else if (run_r) begin
			cnt_nxt = cnt_r + 1'b1;
			if (cnt_r == SAMPLE_END) samp_nxt = 1'b0;
			if (cnt_r == TOTAL_END) begin
				run_nxt  = 1'b0;
				done_nxt = 1'b1;
				cnt_nxt  = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r  <= '0;
			run_r  <= 1'b0;
			samp_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			run_r  <= run_nxt;
			samp_r <= samp_nxt;
			done_r <= done_nxt;
		end
	end

	assign sampling = samp_r;
	assign done     = done_r;
endmodule

// ===== rtl/adcr_unit.sv
// Converter control and result registers with mode sequencing
//
// How it works
// [R1] Start bit 7 starts the converter; clearing it stops per mode.
// [R2] Busy bit 8 is read-only: 1 while converting, else 0.
// [R3] Mode bits 5:4: single, single continuous, scan, scan continuous.
// [R4] Channel bits 3:0 pick the channel, or the first channel of a scan.
// [R5] Codes 0 to 9 select inputs zero to nine; higher codes select none.
// [R6] Software must never program a reserved channel code.
// [R7] Result holds value in bits 9:0 and channel number in bits 15:12.
// [R8] Result stays unchanged until the next completed conversion.
// [R9] Result is read as a whole word; control allows per-bit writes.
// [R10] The ten input lines stay readable digitally, no setup needed.
// [R11] Setting the start bit begins a conversion and sets busy together.
// [R12] Each completion loads result and channel, pulses end-of-conversion request.
// [R13] Completion over an unread result overwrites it and pulses overrun request.
// [R14] Single mode stops after one conversion, clearing busy and start.
// [R15] Reserved register bits read zero and ignore writes.
`timescale 1ns/1ps
module adcr_unit #(
	parameter int NUM_CH = adcr_pkg::NUM_CHANNELS
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] bus_addr,
	input  wire logic [15:0] bus_wdata,
	input  wire logic [15:0] bus_wmask,
	input  wire logic        bus_we,
	input  wire logic        bus_re,
	output logic      [15:0] bus_rdata,
	input  wire logic [9:0]  port_pins,
	input  wire logic [9:0]  conv_data,
	output logic      [9:0]  analog_select,
	output logic             sample_hold,
	output logic             end_of_conversion_request,
	output logic             overrun_error_request
);
	initial begin
		if (NUM_CH != 10) $error("adcr_unit: only ten channels are supported");
	end

	// Decoded one-hot input select
	function automatic logic [9:0] chan_decode(input logic [3:0] ch);
		logic [9:0] sel;
		sel = 10'h000;
		// [R5] reserved codes leave all inputs off
		if (ch <= adcr_pkg::LAST_CHANNEL) sel[ch] = 1'b1;
		return sel;
	endfunction

	// Masked per-bit merge
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
			input logic [15:0] msk);
		return (val & msk) | (old & ~msk);
	endfunction

	logic [3:0]                 ctl_chan_r;
	logic [3:0]                 ctl_chan_nxt;
	adcr_pkg::adcr_mode_type    ctl_mode_r;
	adcr_pkg::adcr_mode_type    ctl_mode_nxt;
	logic                       ctl_start_r;
	logic                       ctl_start_nxt;
	adcr_pkg::adcr_state_type   state_r;
	adcr_pkg::adcr_state_type   state_nxt;
	adcr_pkg::adcr_mode_type    act_mode_r;
	adcr_pkg::adcr_mode_type    act_mode_nxt;
	logic [3:0]                 act_chan_r;
	logic [3:0]                 act_chan_nxt;
	logic [15:0]                result_r;
	logic [15:0]                result_nxt;
	logic                       unread_r;
	logic                       unread_nxt;
	logic                       launch_r;
	logic                       launch_nxt;
	logic [9:0]                 select_r;
	logic [9:0]                 select_nxt;
	logic                       eoc_r;
	logic                       eoc_nxt;
	logic                       ovr_r;
	logic                       ovr_nxt;
	logic [15:0]                rdata_r;
	logic [15:0]                rdata_nxt;

	logic [9:0]  pins_sync;
	logic        timer_done;
	logic        timer_sampling;
	logic        wr_ctl;
	logic        rd_result;
	logic [15:0] ctl_word;
	logic [15:0] ctl_written;
	logic        busy;

	// [R10] digital view of the input lines, always available
	adcr_pin_sync #(
		.WIDTH (10)
	) u_pin_sync (
		.clk     (clk),
		.arst_n  (arst_n),
		.pin_in  (port_pins),
		.pin_out (pins_sync)
	);

	adcr_conv_timer #(
		.SAMPLE (adcr_pkg::SAMPLE_CYC),
		.TOTAL  (adcr_pkg::CONVERT_CYC)
	) u_timer (
		.clk      (clk),
		.arst_n   (arst_n),
		.launch   (launch_r),
		.sampling (timer_sampling),
		.done     (timer_done)
	);

	assign busy      = (state_r == adcr_pkg::ST_CONVERT);
	assign wr_ctl    = bus_we && (bus_addr == adcr_pkg::ADDR_CONTROL);
	assign rd_result = bus_re && (bus_addr == adcr_pkg::ADDR_RESULT);

	// [R15] reserved control bits stay zero
	always_comb begin
		ctl_word = 16'h0000;
		ctl_word[adcr_pkg::CHAN_LSB +: 4] = ctl_chan_r;
		ctl_word[adcr_pkg::MODE_LSB +: 2] = ctl_mode_r;
		ctl_word[adcr_pkg::START_BIT]     = ctl_start_r;
		ctl_word[adcr_pkg::BUSY_BIT]      = busy;
	end

	// [R9] control register takes per-bit writes through the mask
	assign ctl_written = merge(ctl_word, bus_wdata, bus_wmask);

	always_comb begin
		logic hw_stop;
		logic start_eff;
		logic do_launch;
		logic [3:0] next_ch;
		hw_stop      = 1'b0;
		do_launch    = 1'b0;
		next_ch      = ctl_chan_r;
		ctl_chan_nxt = ctl_chan_r;
		ctl_mode_nxt = ctl_mode_r;
		ctl_start_nxt = ctl_start_r;
		state_nxt    = state_r;
		act_mode_nxt = act_mode_r;
		act_chan_nxt = act_chan_r;
		// [R8] result holds between completions
		result_nxt   = result_r;
		unread_nxt   = unread_r;
		select_nxt   = select_r;
		eoc_nxt      = 1'b0;
		ovr_nxt      = 1'b0;
		start_eff    = wr_ctl ? ctl_written[adcr_pkg::START_BIT] : ctl_start_r;

		// Reading the result marks it consumed
		if (rd_result) unread_nxt = 1'b0;

		if (timer_done && busy) begin
			// [R7] value low, channel number high, reserved bits zero
			// [R12] load on every completion
			result_nxt = 16'h0000;
			result_nxt[adcr_pkg::RESULT_LSB +: 10] = conv_data;
			result_nxt[adcr_pkg::CHNUM_LSB +: 4]   = act_chan_r;
			eoc_nxt = 1'b1;
			// [R13] unread result is lost; new data wins over a read
			ovr_nxt    = unread_r && !rd_result;
			unread_nxt = 1'b1;
			// [R3] sequencing by the mode latched at launch
			case (act_mode_r)
				adcr_pkg::MODE_SINGLE: begin
					// [R14] self stop clears busy and start
					hw_stop   = 1'b1;
					state_nxt = adcr_pkg::ST_IDLE;
				end
				adcr_pkg::MODE_SINGLE_CONT: begin
					// [R1] cleared start ends after the current conversion
					if (start_eff) begin
						do_launch = 1'b1;
						next_ch   = ctl_chan_r;
					end else begin
						state_nxt = adcr_pkg::ST_IDLE;
					end
				end
				adcr_pkg::MODE_SCAN: begin
					if (act_chan_r == 4'h0) begin
						hw_stop   = 1'b1;
						state_nxt = adcr_pkg::ST_IDLE;
					end else begin
						do_launch = 1'b1;
						next_ch   = act_chan_r - 4'h1;
					end
				end
				adcr_pkg::MODE_SCAN_CONT: begin
					if (act_chan_r != 4'h0) begin
						do_launch = 1'b1;
						next_ch   = act_chan_r - 4'h1;
					end else if (start_eff) begin
						// [R4] new round restarts from the channel field
						do_launch = 1'b1;
						next_ch   = ctl_chan_r;
					end else begin
						state_nxt = adcr_pkg::ST_IDLE;
					end
				end
				default: begin
					state_nxt = adcr_pkg::ST_IDLE;
				end
			endcase
			if (hw_stop) ctl_start_nxt = 1'b0;
		end

		if (wr_ctl) begin
			// [R15] only defined fields take writes; busy is ignored
			ctl_chan_nxt = ctl_written[adcr_pkg::CHAN_LSB +: 4];
			ctl_mode_nxt = adcr_pkg::adcr_mode_type'(ctl_written[adcr_pkg::MODE_LSB +: 2]);
			// Software set wins over a hardware clear in the same cycle
			if (ctl_written[adcr_pkg::START_BIT]) begin
				ctl_start_nxt = 1'b1;
			end else begin
				ctl_start_nxt = 1'b0;
			end
			// [R11] a rising start aborts and launches with the new fields
			if (ctl_written[adcr_pkg::START_BIT] && (!ctl_start_r || hw_stop)) begin
				do_launch    = 1'b1;
				next_ch      = ctl_written[adcr_pkg::CHAN_LSB +: 4];
				act_mode_nxt = adcr_pkg::adcr_mode_type'(ctl_written[adcr_pkg::MODE_LSB +: 2]);
			end else if (do_launch) begin
				act_mode_nxt = adcr_pkg::adcr_mode_type'(ctl_written[adcr_pkg::MODE_LSB +: 2]);
			end
		end else if (do_launch) begin
			// Mode edits take hold at the next conversion
			act_mode_nxt = ctl_mode_r;
		end

		if (do_launch) begin
			// [R2] busy reflects a conversion in progress
			state_nxt    = adcr_pkg::ST_CONVERT;
			act_chan_nxt = next_ch;
			// [R4] [R6] channel drives the input select directly
			select_nxt   = chan_decode(next_ch);
		end
		launch_nxt = do_launch;
	end

	// Read port: data stand only in the cycle after the strobe
	always_comb begin
		rdata_nxt = 16'h0000;
		if (bus_re) begin
			case (bus_addr)
				adcr_pkg::ADDR_CONTROL: rdata_nxt = ctl_word;
				// [R9] whole-word result only
				adcr_pkg::ADDR_RESULT:  rdata_nxt = result_r;
				// [R10] digital readback of the lines
				adcr_pkg::ADDR_PORT:    rdata_nxt = {6'h00, pins_sync};
				default:                rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_chan_r  <= adcr_pkg::CONTROL_RESET[adcr_pkg::CHAN_LSB +: 4];
			ctl_mode_r  <= adcr_pkg::MODE_SINGLE;
			ctl_start_r <= 1'b0;
			state_r     <= adcr_pkg::ST_IDLE;
			act_mode_r  <= adcr_pkg::MODE_SINGLE;
			act_chan_r  <= 4'h0;
			result_r    <= adcr_pkg::RESULT_RESET;
			unread_r    <= 1'b0;
			launch_r    <= 1'b0;
			select_r    <= 10'h000;
			eoc_r       <= 1'b0;
			ovr_r       <= 1'b0;
			rdata_r     <= 16'h0000;
		end else begin
			ctl_chan_r  <= ctl_chan_nxt;
			ctl_mode_r  <= ctl_mode_nxt;
			ctl_start_r <= ctl_start_nxt;
			state_r     <= state_nxt;
			act_mode_r  <= act_mode_nxt;
			act_chan_r  <= act_chan_nxt;
			result_r    <= result_nxt;
			unread_r    <= unread_nxt;
			launch_r    <= launch_nxt;
			select_r    <= select_nxt;
			eoc_r       <= eoc_nxt;
			ovr_r       <= ovr_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	assign bus_rdata                 = rdata_r;
	assign analog_select             = select_r;
	assign sample_hold               = timer_sampling;
	assign end_of_conversion_request = eoc_r;
	assign overrun_error_request     = ovr_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_start_write;
		wr_ctl && ctl_written[adcr_pkg::START_BIT] && !ctl_start_r;
	endsequence

	sequence s_complete;
		timer_done && busy;
	endsequence

	a_start_sets_busy: assert property (s_start_write |=> busy && ctl_start_r ##1 launch_r == 1'b0) // [R11]
		else $error("start write did not set busy");
	a_busy_readonly: assert property (!busy && !wr_ctl |=> !busy) // [R2]
		else $error("busy rose without a start");
	a_select_decode: assert property (launch_r && act_chan_r > adcr_pkg::LAST_CHANNEL |-> select_r == 10'h000) // [R5]
		else $error("reserved channel selected an input");
	a_result_hold: assert property (!(timer_done && busy) |=> $stable(result_r)) // [R8]
		else $error("result changed without completion");
	a_result_load: assert property (s_complete |=> eoc_r && result_r[15:12] == $past(act_chan_r) // [R12]
			&& result_r[11:10] == 2'b00)
		else $error("completion did not load result and channel");
	a_result_value: assert property (s_complete |=> result_r[9:0] == $past(conv_data)) // [R7]
		else $error("result value field wrong");
	a_overrun_flag: assert property ((s_complete and (unread_r && !rd_result)) |=> ovr_r) // [R13]
		else $error("overrun not flagged");
	a_single_stop: assert property ((s_complete and (act_mode_r == adcr_pkg::MODE_SINGLE && !wr_ctl)) // [R14]
			|=> !busy && !ctl_start_r)
		else $error("single mode did not stop");
	a_ctl_reserved: assert property (bus_re && bus_addr == adcr_pkg::ADDR_CONTROL // [R15]
			|=> bus_rdata[15:9] == 7'h00 && bus_rdata[6] == 1'b0)
		else $error("reserved control bits not zero");
	a_scan_step: assert property ((s_complete and (act_mode_r == adcr_pkg::MODE_SCAN // [R3]
			&& act_chan_r != 4'h0 && !wr_ctl)) |=> launch_r && act_chan_r == $past(act_chan_r) - 4'h1)
		else $error("scan did not step down");
	a_conv_time: assert property (launch_r ##1 !launch_r [*8] |-> ##[380:384] timer_done || launch_r) // [R1]
		else $error("conversion time wrong");
endmodule

// ===== verif/adcr_analog_model.sv
// Behavioural model of the analog input pins and converter core
`timescale 1ns/1ps
module adcr_analog_model (
	input  wire logic       clk,
	input  wire logic [9:0] analog_select,
	input  wire logic       sample_hold,
	input  wire logic [9:0] pin_level,
	output logic      [9:0] port_pins,
	output logic      [9:0] conv_data
);
	logic [3:0] held_r = 4'hf;

	assign port_pins = pin_level;

	// Hold the selected input after sampling
	always @(posedge clk) begin
		if (sample_hold) begin
			held_r <= 4'hf;
			for (int i = 0; i < 10; i++) begin
				if (analog_select[i]) begin
					held_r <= i[3:0];
				end
			end
		end
	end

	assign conv_data = {held_r, ~held_r, 2'b10};
endmodule

// ===== verif/adc_control_result_unit_tb.sv
// Self-checking testbench for the converter control and result unit
`timescale 1ns/1ps
module adc_control_result_unit_tb;
	localparam logic [15:0] CA = adcr_pkg::ADDR_CONTROL;
	localparam logic [15:0] RA = adcr_pkg::ADDR_RESULT;
	localparam logic [15:0] PA = adcr_pkg::ADDR_PORT;
	logic        clk;
	logic        arst_n;
	logic [15:0] bus_addr;
	logic [15:0] bus_wdata;
	logic [15:0] bus_wmask;
	logic        bus_we;
	logic        bus_re;
	logic [15:0] bus_rdata;
	logic [9:0]  port_pins;
	logic [9:0]  conv_data;
	logic [9:0]  analog_select;
	logic        sample_hold;
	logic        end_of_conversion_request;
	logic        overrun_error_request;
	logic [9:0]  pin_level;
	logic        ovr;
	int          error_cnt = 0;
	int          checks = 0;
	int          cycles = 0;
	// Rows: write data, write mask, expected control readback
	logic [47:0] rows [5] = '{48'hffff_ff7f_003f, 48'h0000_0030_000f, 48'h0025_000f_0005,
		48'h0020_00ff_0020, 48'h0000_ffff_0000};

	adcr_unit u_dut (
		.clk                       (clk),
		.arst_n                    (arst_n),
		.bus_addr                  (bus_addr),
		.bus_wdata                 (bus_wdata),
		.bus_wmask                 (bus_wmask),
		.bus_we                    (bus_we),
		.bus_re                    (bus_re),
		.bus_rdata                 (bus_rdata),
		.port_pins                 (port_pins),
		.conv_data                 (conv_data),
		.analog_select             (analog_select),
		.sample_hold               (sample_hold),
		.end_of_conversion_request (end_of_conversion_request),
		.overrun_error_request     (overrun_error_request)
	);

	adcr_analog_model u_model (
		.clk           (clk),
		.analog_select (analog_select),
		.sample_hold   (sample_hold),
		.pin_level     (pin_level),
		.port_pins     (port_pins),
		.conv_data     (conv_data)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Expected result word for a converted channel
	function automatic logic [15:0] res(input logic [3:0] c);
		return {c, 2'b00, c, ~c, 2'b10};
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [15:0] m);
		@(posedge clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wmask <= m;
		bus_we    <= 1'b1;
		@(posedge clk);
		bus_we <= 1'b0;
	endtask

	task automatic rc(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		bus_addr <= a;
		bus_re   <= 1'b1;
		@(posedge clk);
		bus_re <= 1'b0;
		@(negedge clk);
		chk(bus_rdata, exp);
	endtask

	task automatic wait_eoc(output logic o);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (end_of_conversion_request !== 1'b1 && n < 500);
		o = overrun_error_request;
		chk({15'h0000, end_of_conversion_request}, 16'h0001);
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			error_cnt++;
			complete_run();
		end
	end

	initial begin
		arst_n    <= 1'b0;
		bus_addr  <= 16'h0000;
		bus_wdata <= 16'h0000;
		bus_wmask <= 16'h0000;
		bus_we    <= 1'b0;
		bus_re    <= 1'b0;
		pin_level <= 10'h2d5;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rc(CA, 16'h0000);
		rc(RA, 16'h0000);
		foreach (rows[i]) begin
			wr(CA, rows[i][47:32], rows[i][31:16]);
			rc(CA, rows[i][15:0]);
		end
		rc(PA, 16'h02d5);
		pin_level <= 10'h12a;
		repeat (5) @(posedge clk);
		rc(PA, 16'h012a);
		rc(16'hffa6, 16'h0000);
		// Checked results come from valid channel codes only
		// Single conversion of channel 3
		wr(CA, 16'h0083, 16'hffff);
		rc(CA, 16'h0183);
		chk({6'h00, analog_select}, 16'h0008);
		// Sample phase lasts 63 cycles from launch
		chk({15'h0000, sample_hold}, 16'h0001);
		repeat (61) @(negedge clk);
		chk({15'h0000, sample_hold}, 16'h0001);
		@(negedge clk);
		chk({15'h0000, sample_hold}, 16'h0000);
		wait_eoc(ovr);
		chk({15'h0000, ovr}, 16'h0000);
		rc(RA, res(4'h3));
		rc(CA, 16'h0003);
		wr(RA, 16'hffff, 16'hffff);
		rc(RA, res(4'h3));
		// Single continuous: clearing start finishes the current one
		wr(CA, 16'h0095, 16'hffff);
		wait_eoc(ovr);
		rc(RA, res(4'h5));
		wr(CA, 16'h0000, 16'h0080);
		rc(CA, 16'h0115);
		wait_eoc(ovr);
		chk({15'h0000, ovr}, 16'h0000);
		rc(CA, 16'h0015);
		// Scan continuous from channel 1, stopped after first round
		wr(CA, 16'h00b1, 16'hffff);
		wait_eoc(ovr);
		rc(RA, res(4'h1));
		wr(CA, 16'h0000, 16'h0080);
		wait_eoc(ovr);
		rc(RA, res(4'h0));
		rc(CA, 16'h0031);
		// Scan with unread result gives overrun
		wr(CA, 16'h00a1, 16'hffff);
		wait_eoc(ovr);
		chk({15'h0000, ovr}, 16'h0000);
		wait_eoc(ovr);
		chk({15'h0000, ovr}, 16'h0001);
		rc(RA, res(4'h0));
		rc(CA, 16'h0021);
		// Reserved code selects nothing; restart aborts it
		wr(CA, 16'h008a, 16'hffff);
		repeat (3) @(negedge clk);
		chk({6'h00, analog_select}, 16'h0000);
		wr(CA, 16'h0007, 16'h008f);
		wr(CA, 16'h0087, 16'h008f);
		wait_eoc(ovr);
		rc(RA, res(4'h7));
		// Reset in mid-conversion
		wr(CA, 16'h0083, 16'hffff);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rc(CA, 16'h0000);
		complete_run();
	end
endmodule
